// [logic/serial_port_pkg.sv]
/*
  constants for the serial port control and status block: register offsets,
  bit positions, reset values and oversampling phase counts.
  assumes a byte-wide register port driven by the core on core_clk.
*/
package serial_port_pkg;
  // register offsets (index form; the control/status one is not printed)
  localparam logic [7:0] OFF_RX_STATUS   = 8'hbb;
  localparam logic [7:0] OFF_INT_CLK     = 8'hbc;
  localparam logic [7:0] OFF_CTRL_STATUS = 8'hba;
  localparam logic [7:0] OFF_TX_BUF      = 8'hb6;
  localparam logic [7:0] OFF_RX_BUF      = 8'hb7;
  localparam logic [7:0] OFF_BAUD        = 8'hb8;
  localparam logic [7:0] OFF_PRESCALE    = 8'hb9;
  // serial_control_status bits
  localparam int B_PEN   = 7;
  localparam int B_PARITY_SELECT_HIGH = 6;
  localparam int B_PARITY_SELECT_LOW = 5;
  localparam int B_CHAR_LENGTH_HIGH  = 4;
  localparam int B_CHAR_LENGTH_LOW  = 3;
  localparam int B_ERR   = 2;
  localparam int B_RECEIVE_BUFFER_FULL  = 1;
  localparam int B_TRANSMIT_BUFFER_EMPTY  = 0;
  // receive_control_status bits
  localparam int B_DOE   = 7;
  localparam int B_FE    = 6;
  localparam int B_PE    = 5;
  localparam int B_BD    = 4;
  localparam int B_RB9   = 3;
  localparam int B_ATTENTION_MODE  = 2;
  localparam int B_TRANSMITTING_FLAG  = 1;
  localparam int B_RECEIVING_STATUS_FLAG  = 0;
  // interrupt_clock_source_control bits
  localparam int B_TWO_STOP_BITS  = 7;
  localparam int B_BRK   = 6;
  localparam int B_TRANSMIT_PIN_ENABLE  = 5;
  localparam int B_SSEL  = 4;
  localparam int B_RECEIVER_EXTERNAL_CLOCK = 3;
  localparam int B_TRANSMITTER_EXTERNAL_CLOCK = 2;
  localparam int B_ERI   = 1;
  localparam int B_ETI   = 0;
  // reset values
  localparam logic [7:0] RST_CTRL = 8'h01;
  localparam logic [7:0] RST_ZERO = 8'h00;
  // async mode uses 16 ticks per bit; mid sample at half
  localparam logic [3:0] OVERSAMPLE_LAST = 4'hf;
  localparam logic [3:0] OVERSAMPLE_MID  = 4'h7;
endpackage

// [logic/serial_port_control_status.sv]
/*
  serial port control/status with transmitter and receiver: framing of
  7, 8 or 9 data bits, parity, one or two stop bits, loopback, break,
  attention mode, error flags and pin selection.
  assumes a one-cycle register strobe port on core_clk and asynchronous
  serial pins, which are synchronised here before use.
*/
// Behaviour
// - parity select: odd, even, mark, space
// - shared bit: ninth tx bit or parity
// - length bits pick seven or nine bits
// - zero length bits give eight bits
// - both length bits: loopback, nine bits
// - parity enable, only seven/eight bit framing
// - global error set by any error flag
// - buffer full sets on copy, read clears
// - buffer empty sets on load, write clears
// - overrun, framing, parity clear on status read
// - break flag set, cleared by status read
// - ninth received bit held, reset clears
// - attention bit cleared by ninth bit one
// - transmitting flag falls after last stop
// - receiving flag on error, falls line high
// - stop control: one or two stops
// - break bit holds line low
// - mode bit: async or sync
// - rx/tx clock source internal or pin
// - rx/tx interrupt enables gate requests
// - requests pending while flag and enable
// - receive pin always available
// - clock pin input or baud output
`timescale 1ns/1ns
module serial_port_control_status #(
  parameter int DIV_W = 11,
  parameter int PSC_W = 5
) (
  input  wire logic       core_clk,
  input  wire logic       rst_n,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  input  wire logic       serial_in_pin,
  output logic            serial_out_pin,
  output logic            serial_out_pin_oe_n,
  input  wire logic       serial_clock_pin_in,
  output logic            serial_clock_pin_out,
  input  wire logic       serial_clock_pin_dir_out,
  output logic            tx_irq_q,
  output logic            rx_irq_q
);
  logic [7:0] ctrl_q, rxs_q, icc_q, transmit_holding_buffer_q, receive_holding_buffer_q;
  logic [7:0] baud_lo_q, psr_q;
  logic [DIV_W-1:0] div_cnt_q;
  logic [PSC_W-1:0] psc_cnt_q;
  logic       tick16_q, baud_clk_q;
  logic [1:0] rx_sync_q, ck_sync_q;
  logic       ck_prev_q;
  logic       w_ctrl, w_icc, w_transmit_holding_buffer, r_rxs, r_receive_holding_buffer;
  logic       nine, loop, par_on, rx_line, tx_line;
  logic       ck_rise, ck_fall, tx_tick, rx_tick, rx_mid;
  typedef enum logic [1:0] {TX_IDLE, TX_START, TX_BITS, TX_STOP} tx_state_e;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_BITS, RX_STOP} rx_state_e;
  tx_state_e  tx_st_q;
  rx_state_e  rx_st_q;
  logic [3:0] tx_ph_q, rx_ph_q, tx_n_q, rx_n_q;
  logic [8:0] tx_sh_q, rx_sh_q;
  logic       tx_stop2_q, rx_err_fe, rx_err_pe, rx_done, rx_brk;
  logic       tx_load, transmit_buffer_empty_set;

  function automatic logic par_bit(input logic [8:0] d, input logic [1:0] sel);
    unique case (sel)
      2'b00:   par_bit = ~^d;
      2'b01:   par_bit = ^d;
      2'b10:   par_bit = 1'b1;
      default: par_bit = 1'b0;
    endcase
  endfunction

  function automatic logic [3:0] data_bits(input logic [1:0] chl);
    unique case (chl)
      2'b01:   data_bits = 4'h7;
      2'b00:   data_bits = 4'h8;
      default: data_bits = 4'h9;
    endcase
  endfunction

  assign w_ctrl = reg_wr && reg_addr == serial_port_pkg::OFF_CTRL_STATUS;
  assign w_icc  = reg_wr && reg_addr == serial_port_pkg::OFF_INT_CLK;
  assign w_transmit_holding_buffer = reg_wr && reg_addr == serial_port_pkg::OFF_TX_BUF;
  assign r_rxs  = reg_rd && reg_addr == serial_port_pkg::OFF_RX_STATUS;
  assign r_receive_holding_buffer = reg_rd && reg_addr == serial_port_pkg::OFF_RX_BUF;
  assign nine   = ctrl_q[serial_port_pkg::B_CHAR_LENGTH_HIGH];
  // both length bits loop tx to rx
  assign loop   = ctrl_q[serial_port_pkg::B_CHAR_LENGTH_HIGH] & ctrl_q[serial_port_pkg::B_CHAR_LENGTH_LOW];
  // parity only outside nine bit framing
  assign par_on = ctrl_q[serial_port_pkg::B_PEN] & ~nine;

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      rx_sync_q <= 2'b11;
      ck_sync_q <= 2'b00;
      ck_prev_q <= 1'b0;
    end else begin
      rx_sync_q <= {rx_sync_q[0], serial_in_pin};
      ck_sync_q <= {ck_sync_q[0], serial_clock_pin_in};
      ck_prev_q <= ck_sync_q[1];
    end
  end
  assign rx_line = loop ? tx_line : rx_sync_q[1];
  assign ck_rise = ck_sync_q[1] & ~ck_prev_q;
  assign ck_fall = ~ck_sync_q[1] & ck_prev_q;

  // baud generator; prescaler select zero stops the clock
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      psc_cnt_q  <= '0;
      div_cnt_q  <= '0;
      tick16_q   <= 1'b0;
      baud_clk_q <= 1'b0;
    end else begin
      tick16_q <= 1'b0;
      if (psr_q[7:3] == 5'h00) begin
        psc_cnt_q <= '0;
      end else if (psc_cnt_q >= psr_q[7:3] - 5'h01) begin
        psc_cnt_q <= '0;
        if (div_cnt_q >= {psr_q[2:0], baud_lo_q}) begin
          div_cnt_q  <= '0;
          tick16_q   <= 1'b1;
          baud_clk_q <= ~baud_clk_q;
        end else begin
          div_cnt_q <= div_cnt_q + 1'b1;
        end
      end else begin
        psc_cnt_q <= psc_cnt_q + 1'b1;
      end
    end
  end

  // source select per section, sync uses edges
  always_comb begin
    if (icc_q[serial_port_pkg::B_SSEL]) begin
      // tx moves on the rising baud clock, rx samples on the falling one
      tx_tick = icc_q[serial_port_pkg::B_TRANSMITTER_EXTERNAL_CLOCK] ? ck_rise : (tick16_q & baud_clk_q);
      rx_tick = icc_q[serial_port_pkg::B_RECEIVER_EXTERNAL_CLOCK] ? ck_fall : (tick16_q & ~baud_clk_q);
    end else begin
      tx_tick = icc_q[serial_port_pkg::B_TRANSMITTER_EXTERNAL_CLOCK] ? ck_rise : tick16_q;
      rx_tick = icc_q[serial_port_pkg::B_RECEIVER_EXTERNAL_CLOCK] ? ck_rise : tick16_q;
    end
  end

  // registers written by software
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      icc_q     <= serial_port_pkg::RST_ZERO;
      baud_lo_q <= serial_port_pkg::RST_ZERO;
      psr_q     <= serial_port_pkg::RST_ZERO;
    end else begin
      if (w_icc) icc_q <= reg_wdata;
      if (reg_wr && reg_addr == serial_port_pkg::OFF_BAUD) baud_lo_q <= reg_wdata;
      if (reg_wr && reg_addr == serial_port_pkg::OFF_PRESCALE) psr_q <= reg_wdata;
    end
  end

  assign tx_load = (tx_st_q == TX_IDLE) && !ctrl_q[serial_port_pkg::B_TRANSMIT_BUFFER_EMPTY];

  // control/status: transmit_buffer_empty, receive_buffer_full, err live here beside written fields
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      ctrl_q <= serial_port_pkg::RST_CTRL;
      transmit_holding_buffer_q <= serial_port_pkg::RST_ZERO;
    end else begin
      if (w_ctrl) ctrl_q[7:3] <= reg_wdata[7:3];
      if (w_transmit_holding_buffer) transmit_holding_buffer_q <= reg_wdata;
      // load sets empty, write clears; load wins
      if (tx_load) ctrl_q[serial_port_pkg::B_TRANSMIT_BUFFER_EMPTY] <= 1'b1;
      else if (w_transmit_holding_buffer) ctrl_q[serial_port_pkg::B_TRANSMIT_BUFFER_EMPTY] <= 1'b0;
      // copy sets full, buffer read clears
      if (rx_done) ctrl_q[serial_port_pkg::B_RECEIVE_BUFFER_FULL] <= 1'b1;
      else if (r_receive_holding_buffer) ctrl_q[serial_port_pkg::B_RECEIVE_BUFFER_FULL] <= 1'b0;
      // any error flag raises global error
      ctrl_q[serial_port_pkg::B_ERR] <= |rxs_q[7:4];
    end
  end

  // transmitter
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      tx_st_q    <= TX_IDLE;
      tx_ph_q    <= '0;
      tx_n_q     <= '0;
      tx_sh_q    <= '1;
      tx_stop2_q <= 1'b0;
      tx_line    <= 1'b1;
    end else begin
      unique case (tx_st_q)
        TX_IDLE: begin
          tx_line <= 1'b1;
          if (tx_load) begin
            // shared bit is ninth data bit or parity
            tx_sh_q <= nine ? {ctrl_q[serial_port_pkg::B_PARITY_SELECT_LOW], transmit_holding_buffer_q} :
                       {1'b1, transmit_holding_buffer_q};
            // one extra shift puts the first stop bit out, so busy covers it
            tx_n_q  <= data_bits(ctrl_q[4:3]) + {3'b000, par_on} + 4'h1;
            if (par_on && !ctrl_q[serial_port_pkg::B_CHAR_LENGTH_LOW])
              tx_sh_q[8] <= par_bit({1'b0, transmit_holding_buffer_q}, ctrl_q[6:5]);
            // seven bit frames: bit 7 is parity or the stop bit
            if (!nine && ctrl_q[serial_port_pkg::B_CHAR_LENGTH_LOW])
              tx_sh_q[7] <= par_on ? par_bit({2'b00, transmit_holding_buffer_q[6:0]}, ctrl_q[6:5]) : 1'b1;
            tx_ph_q <= '0;
            tx_st_q <= TX_START;
          end
        end
        TX_START: if (tx_tick) begin
          tx_line <= 1'b0;
          tx_st_q <= TX_BITS;
        end
        TX_BITS: if (tx_tick) begin
          tx_ph_q <= tx_ph_q + 4'h1;
          if (icc_q[serial_port_pkg::B_SSEL] || tx_ph_q == serial_port_pkg::OVERSAMPLE_LAST) begin
            tx_ph_q <= '0;
            tx_line <= tx_sh_q[0];
            tx_sh_q <= {1'b1, tx_sh_q[8:1]};
            tx_n_q  <= tx_n_q - 4'h1;
            if (tx_n_q == 4'h1) begin
              tx_st_q    <= TX_STOP;
              tx_stop2_q <= icc_q[serial_port_pkg::B_TWO_STOP_BITS];
            end
          end
        end
        TX_STOP: if (tx_tick) begin
          tx_ph_q <= tx_ph_q + 4'h1;
          if (icc_q[serial_port_pkg::B_SSEL] || tx_ph_q == serial_port_pkg::OVERSAMPLE_LAST) begin
            tx_ph_q <= '0;
            tx_line <= 1'b1;
            if (tx_stop2_q) tx_stop2_q <= 1'b0;
            // busy ends after last stop bit
            else tx_st_q <= TX_IDLE;
          end
        end
      endcase
    end
  end

  assign rx_mid = icc_q[serial_port_pkg::B_SSEL] || rx_ph_q == serial_port_pkg::OVERSAMPLE_LAST;

  // receiver; always one stop bit expected
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      rx_st_q <= RX_IDLE;
      rx_ph_q <= '0;
      rx_n_q  <= '0;
      rx_sh_q <= '0;
    end else begin
      unique case (rx_st_q)
        RX_IDLE: if (rx_tick && !rx_line) begin
          rx_ph_q <= '0;
          rx_st_q <= RX_START;
        end
        RX_START: if (rx_tick) begin
          rx_ph_q <= rx_ph_q + 4'h1;
          if (icc_q[serial_port_pkg::B_SSEL] || rx_ph_q == serial_port_pkg::OVERSAMPLE_MID) begin
            rx_ph_q <= '0;
            rx_n_q  <= data_bits(ctrl_q[4:3]) + {3'b000, par_on};
            rx_st_q <= rx_line ? RX_IDLE : RX_BITS;
          end
        end
        RX_BITS: if (rx_tick) begin
          rx_ph_q <= rx_ph_q + 4'h1;
          if (rx_mid) begin
            rx_ph_q <= '0;
            rx_sh_q <= {rx_line, rx_sh_q[8:1]};
            rx_n_q  <= rx_n_q - 4'h1;
            if (rx_n_q == 4'h1) rx_st_q <= RX_STOP;
          end
        end
        RX_STOP: if (rx_tick) begin
          rx_ph_q <= rx_ph_q + 4'h1;
          if (rx_mid) rx_st_q <= RX_IDLE;
        end
      endcase
    end
  end

  // aligned frame: 7-bit frames without parity arrive shifted further
  logic [8:0] rx_word;
  always_comb begin
    unique case (data_bits(ctrl_q[4:3]) + {3'b000, par_on})
      4'h7:    rx_word = {2'b00, rx_sh_q[8:2]};
      4'h8:    rx_word = {1'b0, rx_sh_q[8:1]};
      default: rx_word = rx_sh_q;
    endcase
  end
  assign rx_done   = rx_st_q == RX_STOP && rx_tick && rx_mid;
  assign rx_brk    = rx_done && !rx_line && rx_word == 9'h000;
  assign rx_err_fe = rx_done && !rx_line;
  assign rx_err_pe = rx_done && par_on &&
    (ctrl_q[serial_port_pkg::B_CHAR_LENGTH_LOW] ?
      rx_word[7] != par_bit({2'b00, rx_word[6:0]}, ctrl_q[6:5]) :
      rx_word[8] != par_bit({1'b0, rx_word[7:0]}, ctrl_q[6:5]));

  // receive buffer and status; set wins over read clear
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      rxs_q  <= serial_port_pkg::RST_ZERO;
      receive_holding_buffer_q <= serial_port_pkg::RST_ZERO;
    end else begin
      if (reg_wr && reg_addr == serial_port_pkg::OFF_RX_STATUS)
        rxs_q[serial_port_pkg::B_ATTENTION_MODE] <= reg_wdata[serial_port_pkg::B_ATTENTION_MODE];
      if (r_rxs) rxs_q[7:4] <= 4'h0;
      if (rx_done) begin
        if (ctrl_q[serial_port_pkg::B_RECEIVE_BUFFER_FULL] && !r_receive_holding_buffer)
          rxs_q[serial_port_pkg::B_DOE] <= 1'b1;
        if (rx_err_fe && !rx_brk) rxs_q[serial_port_pkg::B_FE] <= 1'b1;
        if (rx_err_pe) rxs_q[serial_port_pkg::B_PE] <= 1'b1;
        if (rx_brk) rxs_q[serial_port_pkg::B_BD] <= 1'b1;
        receive_holding_buffer_q <= rx_word[7:0];
        // ninth bit kept in nine bit framing
        if (nine) rxs_q[serial_port_pkg::B_RB9] <= rx_word[8];
        if (nine && rx_word[8]) rxs_q[serial_port_pkg::B_ATTENTION_MODE] <= 1'b0;
      end
      rxs_q[serial_port_pkg::B_TRANSMITTING_FLAG] <= tx_st_q != TX_IDLE || tx_load;
      // set on error or break, drop on line high
      if (rx_err_fe) rxs_q[serial_port_pkg::B_RECEIVING_STATUS_FLAG] <= 1'b1;
      else if (rx_line) rxs_q[serial_port_pkg::B_RECEIVING_STATUS_FLAG] <= 1'b0;
    end
  end

  // read data one cycle after strobe
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      reg_rdata <= serial_port_pkg::RST_ZERO;
    end else if (reg_rd) begin
      unique case (reg_addr)
        serial_port_pkg::OFF_CTRL_STATUS: reg_rdata <= ctrl_q;
        serial_port_pkg::OFF_RX_STATUS:   reg_rdata <= rxs_q;
        serial_port_pkg::OFF_INT_CLK:     reg_rdata <= icc_q;
        serial_port_pkg::OFF_TX_BUF:      reg_rdata <= transmit_holding_buffer_q;
        serial_port_pkg::OFF_RX_BUF:      reg_rdata <= receive_holding_buffer_q;
        serial_port_pkg::OFF_BAUD:        reg_rdata <= baud_lo_q;
        serial_port_pkg::OFF_PRESCALE:    reg_rdata <= psr_q;
        default:                          reg_rdata <= serial_port_pkg::RST_ZERO;
      endcase
    end else begin
      reg_rdata <= serial_port_pkg::RST_ZERO;
    end
  end

  // pins and requests, all registered
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      serial_out_pin       <= 1'b1;
      serial_out_pin_oe_n  <= 1'b1;
      serial_clock_pin_out <= 1'b0;
      tx_irq_q             <= 1'b0;
      rx_irq_q             <= 1'b0;
    end else begin
      // break holds line low; loopback keeps pin idle
      serial_out_pin <= icc_q[serial_port_pkg::B_BRK] ? 1'b0 : (loop ? 1'b1 : tx_line);
      serial_out_pin_oe_n <= ~icc_q[serial_port_pkg::B_TRANSMIT_PIN_ENABLE];
      // baud clock driven out when pin is output
      serial_clock_pin_out <= serial_clock_pin_dir_out & baud_clk_q;
      // level requests while flag and enable
      tx_irq_q <= ctrl_q[serial_port_pkg::B_TRANSMIT_BUFFER_EMPTY] & icc_q[serial_port_pkg::B_ETI];
      rx_irq_q <= ctrl_q[serial_port_pkg::B_RECEIVE_BUFFER_FULL] & icc_q[serial_port_pkg::B_ERI];
    end
  end
endmodule

// [bench/serial_port_asserts.sv]
/*
  port checker for serial_port_control_status, bound to every instance.
  assumes one clock domain, core_clk, with synchronous active-low rst_n.
*/
`timescale 1ns/1ns
module serial_port_asserts (
  input wire logic       core_clk,
  input wire logic       rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic       serial_in_pin,
  input wire logic       serial_out_pin,
  input wire logic       serial_out_pin_oe_n,
  input wire logic       serial_clock_pin_in,
  input wire logic       serial_clock_pin_out,
  input wire logic       serial_clock_pin_dir_out,
  input wire logic       tx_irq_q,
  input wire logic       rx_irq_q
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);
  logic icw;
  assign icw = reg_wr && reg_addr == serial_port_pkg::OFF_INT_CLK;
  sequence rd_at(logic [7:0] x);
    reg_rd && reg_addr == x;
  endsequence
  property p_oe;
    logic e;
    (icw, e = reg_wdata[serial_port_pkg::B_TRANSMIT_PIN_ENABLE]) |-> ##2 serial_out_pin_oe_n == !e;
  endproperty
  chk_reset_lines_quiet: assert property ($rose(rst_n) |-> serial_out_pin &&
    serial_out_pin_oe_n && !tx_irq_q && !rx_irq_q) else $error("pins not idle after reset");
  chk_pin_enable_follows: assert property (p_oe)
    else $error("pin enable does not follow control");
  chk_break_holds_low: assert property (icw && reg_wdata[serial_port_pkg::B_BRK]
    |-> ##2 !serial_out_pin) else $error("break bit did not pull line low");
  chk_tx_irq_gated: assert property (icw && !reg_wdata[serial_port_pkg::B_ETI]
    |-> ##2 !tx_irq_q) else $error("tx request with enable clear");
  chk_rx_irq_gated: assert property (icw && !reg_wdata[serial_port_pkg::B_ERI]
    |-> ##2 !rx_irq_q) else $error("rx request with enable clear");
  chk_clk_out_off: assert property ((!serial_clock_pin_dir_out)[*2]
    |-> !serial_clock_pin_out) else $error("clock pin driven while input");
  chk_buf_read_clears: assert property (rd_at(8'hb7) ##1 rd_at(8'hba)
    |=> !reg_rdata[serial_port_pkg::B_RECEIVE_BUFFER_FULL]) else $error("full flag kept after read");
  chk_err_read_clears: assert property (rd_at(8'hbb) ##1 rd_at(8'hbb)
    |=> reg_rdata[7:4] == 4'h0) else $error("error flags kept after status read");
  cover property (icw && reg_wdata[serial_port_pkg::B_BRK]);
  cover property ($rose(rx_irq_q));
  cover property (rd_at(8'hbb) ##1 rd_at(8'hbb));
endmodule

bind serial_port_control_status serial_port_asserts chk_u (
  .core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .serial_in_pin(serial_in_pin),
  .serial_out_pin(serial_out_pin), .serial_out_pin_oe_n(serial_out_pin_oe_n),
  .serial_clock_pin_in(serial_clock_pin_in), .serial_clock_pin_out(serial_clock_pin_out),
  .serial_clock_pin_dir_out(serial_clock_pin_dir_out), .tx_irq_q(tx_irq_q),
  .rx_irq_q(rx_irq_q));

// [bench/serial_peer.sv]
/*
  remote serial transmitter facing the receive line and the clock pin.
  assumes the caller gives the bit period in core_clk cycles.
*/
`timescale 1ns/1ns
module serial_peer (
  input  wire logic core_clk,
  output logic      line,
  output logic      ext_clk
);
  // external clock stands still: no frame is clocked from the pin
  initial begin
    line = 1'b1;
    ext_clk = 1'b0;
  end
  // frames sent with no receive pin setup
  // start, data lsb first, parity, stop
  task automatic send(input logic [15:0] bits, input int n, input int p);
    for (int i = 0; i < n; i++) begin
      line <= bits[i];
      repeat (p) @(posedge core_clk);
    end
    line <= 1'b1;
  endtask
endmodule

// [bench/tb.sv]
/*
  testbench for serial_port_control_status: registers, tx framing, rx errors.
  assumes serial_peer on the receive line; bit period is measured, not known.
*/
`timescale 1ns/1ns
module tb;
  logic        clk, rst_n, wr_s, rd_s, dir_o, tx, oe_n, ck_o, ti, ri, rxl, cki, st;
  logic [7:0]  ad, wd, rdat, a, b, v;
  logic [15:0] fr, g;
  int          n_fail, n_checks, p, nb, k;
  logic [7:0]  cfg [10] = '{8'h00, 8'h00, 8'h08, 8'h88, 8'ha8, 8'hc8, 8'he8, 8'h80, 8'h30, 8'h90};
  serial_port_control_status dut_u (
    .core_clk(clk), .rst_n(rst_n), .reg_addr(ad), .reg_wdata(wd), .reg_wr(wr_s),
    .reg_rd(rd_s), .reg_rdata(rdat), .serial_in_pin(rxl), .serial_out_pin(tx),
    .serial_out_pin_oe_n(oe_n), .serial_clock_pin_in(cki), .serial_clock_pin_out(ck_o),
    .serial_clock_pin_dir_out(dir_o), .tx_irq_q(ti), .rx_irq_q(ri));
  serial_peer peer_u (.core_clk(clk), .line(rxl), .ext_clk(cki));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] x, input logic [7:0] d);
    @(posedge clk);
    wr_s <= 1'b1;
    ad <= x;
    wd <= d;
    @(posedge clk);
    wr_s <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] x, output logic [7:0] d);
    @(posedge clk);
    rd_s <= 1'b1;
    ad <= x;
    @(posedge clk);
    rd_s <= 1'b0;
    #1 d = rdat;
  endtask
  // back-to-back reads: no gap between the two strobes
  task automatic rd2(input logic [7:0] x, input logic [7:0] y, output logic [7:0] d,
                     output logic [7:0] e);
    @(posedge clk);
    rd_s <= 1'b1;
    ad <= x;
    @(posedge clk);
    ad <= y;
    #1 d = rdat;
    @(posedge clk);
    rd_s <= 1'b0;
    #1 e = rdat;
  endtask
  task automatic rdc(input logic [7:0] x, input logic [7:0] e);
    rd(x, a);
    check($sformatf("reg %h", x), a, e);
  endtask
  function automatic int frame(input logic [7:0] c, input logic [8:0] d, output logic [15:0] f);
    int nd;
    logic pb;
    nd = (c[4:3] == 2'b01) ? 7 : (c[4] ? 9 : 8);
    f = 16'hffff;
    f[0] = 1'b0;
    for (int i = 0; i < nd; i++) f[i+1] = d[i];
    pb = (nd == 7) ? ^d[6:0] : ^d[7:0];
    if (c[7] && !c[4]) begin
      f[nd+1] = c[6] ? !c[5] : (c[5] ? pb : !pb);
      return nd + 3;
    end
    return nd + 2;
  endfunction
  // waits for the start bit, then samples mid-bit; ends mid slot n
  task automatic grab(input int n, output logic [15:0] f);
    f = 16'hffff;
    for (int i = 0; i < 20000 && tx; i++) @(posedge clk);
    repeat (p / 2) @(posedge clk);
    for (int i = 0; i < n; i++) begin
      f[i] = tx;
      repeat (p) @(posedge clk);
    end
  endtask
  // peer frames sent by rx are 8 bits, even parity; fl flips parity or stop
  task automatic rx(input logic [8:0] d, input logic [1:0] fl);
    nb = frame(8'ha0, d, fr);
    fr[nb-2] = fr[nb-2] ^ fl[0];
    fr[nb-1] = !fl[1];
    peer_u.send(fr, nb, p);
    repeat (p) @(posedge clk);
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    repeat (90000) @(posedge clk);
    n_fail++;
    results();
  end
  initial begin
    {rst_n, wr_s, rd_s, dir_o, ad, wd} = '0;
    void'($urandom(32'hd0e859bd));
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    rdc(8'hba, 8'h01);
    rdc(8'hbb, 8'h00);
    rdc(8'hbc, 8'h00);
    rdc(8'h00, 8'h00);
    check("idle pins", {tx, oe_n, ck_o}, 3'b110);
    $display("test reset done");
    for (int i = 0; i < 5; i++) begin
      v = (i == 0) ? 8'hff : (i == 1) ? 8'h00 : 8'($urandom);
      wr(8'hbc, v);
      rdc(8'hbc, v);
      check("pin enable", oe_n, !v[5]);
      check("break line", tx, !v[6]);
      check("tx request", {ti, ri}, {v[0], 1'b0});
    end
    wr(8'hbc, 8'h00);
    wr(8'hba, 8'hff);
    rdc(8'hba, 8'hf9);
    wr(8'hbb, 8'hff);
    rdc(8'hbb, 8'h04);
    wr(8'h00, 8'hff);
    rdc(8'h00, 8'h00);
    wr(8'hbb, 8'h00);
    wr(8'hba, 8'h00);
    $display("test registers done");
    // prescale 1, divisor 1: the period is then taken from a start bit
    wr(8'hb9, 8'h08);
    wr(8'hb8, 8'h01);
    wr(8'hbc, 8'h20);
    wr(8'hb6, 8'h01);
    for (int i = 0; i < 20000 && tx; i++) @(posedge clk);
    for (p = 0; p < 5000 && !tx; p++) @(posedge clk);
    repeat (12 * p) @(posedge clk);
    dir_o <= 1'b1;
    k = 0;
    repeat (2 * p) begin
      @(posedge clk);
      k += ck_o;
    end
    check("clock out", k > 0, 1'b1);
    dir_o <= 1'b0;
    for (int i = 0; i < 10; i++) begin
      st = (i == 1 || i == 8);
      b = 8'($urandom);
      wr(8'hba, cfg[i]);
      wr(8'hbc, {st, 7'h20});
      wr(8'hb6, b);
      nb = frame(cfg[i], {cfg[i][5], b}, fr);
      grab(nb, g);
      check("tx frame", g, fr);
      rdc(8'hbb, {6'h00, st, 1'b0});
      repeat (p) @(posedge clk);
      rdc(8'hbb, 8'h00);
      rdc(8'hba, {cfg[i][7:3], 3'b001});
    end
    // sync mode on the internal clock: one bit per baud clock, p / 8 cycles
    p = p / 8;
    wr(8'hba, 8'h00);
    wr(8'hbc, 8'h30);
    b = 8'($urandom);
    wr(8'hb6, b);
    nb = frame(8'h00, {1'b0, b}, fr);
    grab(nb, g);
    check("sync frame", g, fr);
    p = p * 8;
    $display("test transmit done");
    wr(8'hba, 8'ha0);
    wr(8'hbc, 8'h02);
    v = 8'($urandom);
    rx({1'b0, v}, 2'b00);
    check("rx request", ri, 1'b1);
    rd2(8'hb7, 8'hba, a, b);
    check("rx data", a, v);
    check("rx ctrl", b, 8'ha1);
    rdc(8'hbb, 8'h00);
    rx({1'b0, 8'($urandom)}, 2'b01);
    rd(8'hba, b);
    check("error flag", b[2], 1'b1);
    rd2(8'hbb, 8'hbb, a, b);
    check("parity error", {a[7:4], b[7:4]}, 8'h20);
    rd(8'hb7, a);
    rx(9'h055, 2'b10);
    rd(8'hbb, a);
    check("framing error", a & 8'hf1, 8'h40);
    rd(8'hb7, a);
    rx({1'b0, 8'($urandom)}, 2'b00);
    rx({1'b0, 8'($urandom)}, 2'b00);
    rdc(8'hbb, 8'h80);
    rd(8'hb7, a);
    // break of one frame length: a longer one would start a false frame;
    // status is read after the stop sample, before the line returns high
    fork
      peer_u.send(16'h0000, 11, p);
      begin
        repeat (11 * p - 8) @(posedge clk);
        rdc(8'hbb, 8'h11);
      end
    join
    repeat (p) @(posedge clk);
    rdc(8'hbb, 8'h00);
    rd(8'hb7, a);
    $display("test receive done");
    wr(8'hbc, 8'h20);
    wr(8'hba, 8'h38);
    wr(8'hbb, 8'h04);
    v = 8'($urandom);
    wr(8'hb6, v);
    k = 0;
    repeat (14 * p) begin
      @(posedge clk);
      k += !tx;
    end
    check("loop pin", k, 0);
    rd2(8'hb7, 8'hbb, a, b);
    check("loop data", a, v);
    check("loop status", b, 8'h08);
    $display("test loopback done");
    results();
  end
endmodule
